//--- verilog/amd_pkg.sv
// address map constants and carriers for the cpu address decoder
// assumes a single 40 MHz clock domain, no software-visible registers
package amd_pkg;

    // ------------------------------------------------------------
    // segment codes on virtual address [31:29]
    // ------------------------------------------------------------
    localparam int SEG_HI = 31;
    localparam int SEG_LO = 29;
    localparam logic [2:0] SEG_CACHED   = 3'h4;
    localparam logic [2:0] SEG_UNCACHED = 3'h5;

    // ------------------------------------------------------------
    // cpu-bus region bases and masks
    // ------------------------------------------------------------
    localparam logic [31:0] CORE_BASE  = 32'h1fff0000;
    localparam logic [31:0] CORE_MASK  = 32'hffff0000;
    localparam logic [31:0] HOLE_BASE  = 32'h1ff80000;
    localparam logic [31:0] HOLE_MASK  = 32'hfff80000;
    localparam logic [31:0] CFG_BASE   = 32'h1ff40000;
    localparam logic [31:0] ATTR_BASE  = 32'h1ff00000;
    localparam logic [31:0] QMB_MASK   = 32'hfffc0000;
    localparam logic [31:0] IO_BASE    = 32'h1fe00000;
    localparam logic [31:0] IO_MASK    = 32'hfff00000;
    localparam logic [31:0] ROM_BASE   = 32'h1fc00000;
    localparam logic [31:0] ROM_MASK   = 32'hffe00000;
    localparam logic [31:0] X8_BASE    = 32'h18000000;
    localparam logic [31:0] X16_BASE   = 32'h14000000;
    localparam logic [31:0] X32_BASE   = 32'h10000000;
    localparam logic [31:0] X_MASK     = 32'hfc000000;
    localparam logic [31:0] SD_BASE    = 32'h00000000;
    localparam logic [31:0] SD2_MASK   = 32'hffe00000;
    localparam logic [31:0] SD8_MASK   = 32'hff800000;
    localparam logic [31:0] SD16_MASK  = 32'hff000000;

    // ------------------------------------------------------------
    // target address forming
    // ------------------------------------------------------------
    localparam logic [23:0] PB_CFG_BASE  = 24'hf40000;
    localparam logic [23:0] PB_ATTR_BASE = 24'hf00000;
    localparam logic [23:0] PB_IO_BASE   = 24'he00000;
    localparam logic [23:0] EX_ROM_BASE  = 24'hc00000;
    localparam logic [31:0] SD_LOW_BASE  = 32'h00000000;
    localparam logic [31:0] SD_HIGH_BASE = 32'h01000000;
    localparam int CFG_OFS_W  = 18;
    localparam int IO_OFS_W   = 20;
    localparam int ROM_OFS_W  = 21;
    localparam int DMX_W      = 24;
    localparam int SD2_OFS_W  = 21;
    localparam int SD16_OFS_W = 24;
    localparam int SLOT_LO_1K = 10;
    localparam int SLOT_LO_4K = 12;

    typedef enum logic [1:0] {
        AMD_SD_2MB,
        AMD_SD_8MB,
        AMD_SD_16MB
    } amd_sdram_size_type;

    typedef enum logic [3:0] {
        AMD_TGT_NONE,
        AMD_TGT_CORE,
        AMD_TGT_CFG,
        AMD_TGT_ATTR,
        AMD_TGT_IO,
        AMD_TGT_ROM,
        AMD_TGT_X8,
        AMD_TGT_X16,
        AMD_TGT_X32,
        AMD_TGT_SDRAM
    } amd_target_type;

    typedef enum logic [1:0] {
        AMD_SEG_USER,
        AMD_SEG_CACHED,
        AMD_SEG_UNCACHED,
        AMD_SEG_UPPER
    } amd_segment_type;

    // cpu request
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] vaddr;
    } amd_req_type;

    // decoded route
    typedef struct packed {
        logic            valid;
        logic            write;
        amd_segment_type segment;
        amd_target_type  target;
        logic [31:0]     phys;
        logic [23:0]     peripheral_bus_addr;
        logic [31:0]     ebus_addr;
        logic            ebus_wide;
        logic [7:0]      slot;
        logic [31:0]     sdram_addr;
    } amd_route_type;

endpackage : amd_pkg

//--- verilog/amd_decoder.sv
// cpu virtual address classifier, alias stub and region router
// assumes requests come from logic on ref_clk; strap pin is asynchronous
`timescale 1ns/1ps
`default_nettype none

module amd_decoder
    import amd_pkg::*;
#(
    parameter amd_sdram_size_type SDRAM_SIZE = AMD_SD_16MB
) (
    input  wire logic          ref_clk,
    input  wire logic          rst,
    input  wire amd_req_type   req,
    input  wire logic          strap_pin,
    input  wire logic          ebus_demux_mode,
    output amd_route_type      route,
    output logic               ebus_wiring_sel,
    output logic               unmapped_hit
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (SDRAM_SIZE != AMD_SD_2MB && SDRAM_SIZE != AMD_SD_8MB
        && SDRAM_SIZE != AMD_SD_16MB) begin : g_bad_size
        $error("unsupported sdram size");
    end

    // ------------------------------------------------------------
    // strap capture
    // ------------------------------------------------------------
    // two stages on the raw pin, kept out of reset so that they go on
    // tracking the strap while rst is held; a cleared stage would hand 0 to the capture
    logic strap_s1_r;
    logic strap_s2_r;
    logic strap_taken_r;
    logic wiring_r;

    always_ff @(posedge ref_clk) begin
        strap_s1_r <= strap_pin;
        strap_s2_r <= strap_s1_r;
    end

    // async reset clears the flag; the first clocked edge after release grabs the strap
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            strap_taken_r <= 1'b0;
            wiring_r      <= 1'b0;
        end else if (!strap_taken_r) begin
            strap_taken_r <= 1'b1;
            wiring_r      <= strap_s2_r;
        end
    end

    // ------------------------------------------------------------
    // segment classification and alias stub
    // ------------------------------------------------------------
    amd_segment_type seg_nxt;
    logic [31:0]     phys_nxt;

    always_comb begin
        unique case (req.vaddr[SEG_HI:SEG_LO])
            SEG_CACHED:   seg_nxt = AMD_SEG_CACHED;
            SEG_UNCACHED: seg_nxt = AMD_SEG_UNCACHED;
            3'h6, 3'h7:   seg_nxt = AMD_SEG_UPPER;
            default:      seg_nxt = AMD_SEG_USER;
        endcase
    end

    always_comb begin
        phys_nxt = req.vaddr;
        if (seg_nxt == AMD_SEG_CACHED || seg_nxt == AMD_SEG_UNCACHED) begin
            phys_nxt[SEG_HI:SEG_LO] = 3'h0;
        end
    end

    // ------------------------------------------------------------
    // region decode
    // ------------------------------------------------------------
    logic [31:0]    sd_mask;
    amd_target_type tgt_nxt;

    always_comb begin
        unique case (SDRAM_SIZE)
            AMD_SD_2MB: sd_mask = SD2_MASK;
            AMD_SD_8MB: sd_mask = SD8_MASK;
            default:    sd_mask = SD16_MASK;
        endcase
    end

    // upper segment maps to nothing, so it falls out as unmapped
    always_comb begin
        tgt_nxt = AMD_TGT_NONE;
        if (seg_nxt == AMD_SEG_UPPER) begin
            tgt_nxt = AMD_TGT_NONE;
        end else if ((phys_nxt & CORE_MASK) == CORE_BASE) begin
            tgt_nxt = AMD_TGT_CORE;
        end else if ((phys_nxt & HOLE_MASK) == HOLE_BASE) begin
            tgt_nxt = AMD_TGT_NONE;
        end else if ((phys_nxt & QMB_MASK) == CFG_BASE) begin
            tgt_nxt = AMD_TGT_CFG;
        end else if ((phys_nxt & QMB_MASK) == ATTR_BASE) begin
            tgt_nxt = AMD_TGT_ATTR;
        end else if ((phys_nxt & IO_MASK) == IO_BASE) begin
            tgt_nxt = AMD_TGT_IO;
        end else if ((phys_nxt & ROM_MASK) == ROM_BASE) begin
            tgt_nxt = AMD_TGT_ROM;
        end else if ((phys_nxt & X_MASK) == X8_BASE) begin
            tgt_nxt = AMD_TGT_X8;
        end else if ((phys_nxt & X_MASK) == X16_BASE) begin
            tgt_nxt = AMD_TGT_X16;
        end else if ((phys_nxt & X_MASK) == X32_BASE) begin
            tgt_nxt = AMD_TGT_X32;
        end else if ((phys_nxt & sd_mask) == SD_BASE) begin
            tgt_nxt = AMD_TGT_SDRAM;
        end
    end

    // ------------------------------------------------------------
    // target address forming
    // ------------------------------------------------------------
    logic [23:0] pb_nxt;
    logic [31:0] eb_nxt;
    logic        wide_nxt;
    logic [7:0]  slot_nxt;
    logic [31:0] sd_nxt;

    always_comb begin
        pb_nxt   = 24'h000000;
        eb_nxt   = 32'h00000000;
        wide_nxt = 1'b0;
        slot_nxt = 8'h00;
        sd_nxt   = 32'h00000000;
        unique case (tgt_nxt)
            AMD_TGT_CFG: begin
                pb_nxt   = PB_CFG_BASE | {6'h00, phys_nxt[CFG_OFS_W-1:0]};
                slot_nxt = phys_nxt[SLOT_LO_1K +: 8];
            end
            AMD_TGT_ATTR: begin
                pb_nxt   = PB_ATTR_BASE | {6'h00, phys_nxt[CFG_OFS_W-1:0]};
                slot_nxt = phys_nxt[SLOT_LO_1K +: 8];
            end
            AMD_TGT_IO: begin
                pb_nxt   = PB_IO_BASE | {4'h0, phys_nxt[IO_OFS_W-1:0]};
                slot_nxt = phys_nxt[SLOT_LO_4K +: 8];
            end
            AMD_TGT_ROM: begin
                eb_nxt = {8'h00, EX_ROM_BASE | {3'h0, phys_nxt[ROM_OFS_W-1:0]}};
            end
            AMD_TGT_X8, AMD_TGT_X16: begin
                eb_nxt = {8'h00, phys_nxt[DMX_W-1:0]};
            end
            AMD_TGT_X32: begin
                // 32-bit devices need the multiplexed bus; demux mode keeps 24 bits
                wide_nxt = !ebus_demux_mode;
                eb_nxt   = ebus_demux_mode ? {8'h00, phys_nxt[DMX_W-1:0]}
                                           : phys_nxt;
            end
            AMD_TGT_SDRAM: begin
                if (SDRAM_SIZE == AMD_SD_2MB) begin
                    sd_nxt = SD_LOW_BASE | {11'h000, phys_nxt[SD2_OFS_W-1:0]};
                end else begin
                    sd_nxt = SD_HIGH_BASE | {8'h00, phys_nxt[SD16_OFS_W-1:0]};
                end
            end
            default: begin
            end
        endcase
    end

    // ------------------------------------------------------------
    // registered route
    // ------------------------------------------------------------
    // one-cycle pipeline so every output is a flop
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            route        <= '0;
            unmapped_hit <= 1'b0;
        end else begin
            route.valid      <= req.valid;
            route.write      <= req.write;
            route.segment    <= seg_nxt;
            route.target     <= req.valid ? tgt_nxt : AMD_TGT_NONE;
            route.phys       <= phys_nxt;
            route.peripheral_bus_addr  <= pb_nxt;
            // sdram never shows on external pins
            route.ebus_addr  <= eb_nxt;
            route.ebus_wide  <= wide_nxt;
            route.slot       <= slot_nxt;
            route.sdram_addr <= sd_nxt;
            unmapped_hit     <= req.valid && tgt_nxt == AMD_TGT_NONE;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ebus_wiring_sel <= 1'b0;
        end else begin
            ebus_wiring_sel <= wiring_r;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_alias;
        @(posedge ref_clk) disable iff (rst)
        req.vaddr[31:30] == 2'h2 |=> route.phys[31:29] == 3'h0;
    endproperty
    a_alias: assert property (p_alias) else $error("kernel alias not cleared");

    property p_user;
        @(posedge ref_clk) disable iff (rst)
        !req.vaddr[31] |=> route.phys == $past(req.vaddr);
    endproperty
    a_user: assert property (p_user) else $error("user address modified");

    property p_upper;
        @(posedge ref_clk) disable iff (rst)
        req.vaddr[31:30] == 2'h3 |=> route.target == AMD_TGT_NONE
                                     && route.phys == $past(req.vaddr);
    endproperty
    a_upper: assert property (p_upper) else $error("upper segment reached target");

    property p_core;
        @(posedge ref_clk) disable iff (rst)
        route.target == AMD_TGT_CORE |-> route.peripheral_bus_addr == 24'h000000
                                         && route.phys[31:16] == 16'h1fff;
    endproperty
    a_core: assert property (p_core) else $error("core region leaked");

    property p_cfg;
        @(posedge ref_clk) disable iff (rst)
        route.target == AMD_TGT_CFG |-> route.peripheral_bus_addr == {6'h3d, route.phys[17:0]};
    endproperty
    a_cfg: assert property (p_cfg) else $error("config address wrong");

    property p_io;
        @(posedge ref_clk) disable iff (rst)
        route.target == AMD_TGT_IO |-> route.peripheral_bus_addr[23:20] == 4'he
                                       && route.slot == route.phys[19:12];
    endproperty
    a_io: assert property (p_io) else $error("io address wrong");

    property p_x8;
        @(posedge ref_clk) disable iff (rst)
        route.target == AMD_TGT_X8 |-> route.ebus_addr == {8'h00, route.phys[23:0]};
    endproperty
    a_x8: assert property (p_x8) else $error("8-bit external address wrong");

    property p_sd;
        @(posedge ref_clk) disable iff (rst)
        route.target == AMD_TGT_SDRAM |-> route.ebus_addr == 32'h00000000;
    endproperty
    a_sd: assert property (p_sd) else $error("sdram on external bus");

    property p_unmapped;
        @(posedge ref_clk) disable iff (rst)
        req.valid && req.vaddr[31:19] == 13'h03ff |=> unmapped_hit;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("hole not flagged");

    property p_attr;
        @(posedge ref_clk) disable iff (rst)
        route.target == AMD_TGT_ATTR |-> route.peripheral_bus_addr == {6'h3c, route.phys[17:0]};
    endproperty
    a_attr: assert property (p_attr) else $error("attribute address wrong");

    property p_peripheral_bus_idle;
        @(posedge ref_clk) disable iff (rst)
        route.valid && !(route.target inside {AMD_TGT_CFG, AMD_TGT_ATTR, AMD_TGT_IO})
            |-> route.peripheral_bus_addr == 24'h000000;
    endproperty
    a_peripheral_bus_idle: assert property (p_peripheral_bus_idle) else $error("stray peripheral address");

    property p_x16;
        @(posedge ref_clk) disable iff (rst)
        route.target == AMD_TGT_X16 |-> route.ebus_addr == {8'h00, route.phys[23:0]};
    endproperty
    a_x16: assert property (p_x16) else $error("16-bit external address wrong");

    property p_x32;
        @(posedge ref_clk) disable iff (rst)
        route.target == AMD_TGT_X32 && route.ebus_wide |-> route.ebus_addr == route.phys;
    endproperty
    a_x32: assert property (p_x32) else $error("32-bit external address wrong");

    property p_wide;
        @(posedge ref_clk) disable iff (rst)
        route.valid && route.ebus_wide |-> route.target == AMD_TGT_X32;
    endproperty
    a_wide: assert property (p_wide) else $error("wide address outside 32-bit region");

    property p_rom;
        @(posedge ref_clk) disable iff (rst)
        route.target == AMD_TGT_ROM |-> route.ebus_addr[31:21] == 11'h006
                                        && route.ebus_addr[20:0] == route.phys[20:0];
    endproperty
    a_rom: assert property (p_rom) else $error("rom address wrong");

    property p_sdbase;
        @(posedge ref_clk) disable iff (rst)
        route.target == AMD_TGT_SDRAM
            |-> route.sdram_addr[31:24] == ((SDRAM_SIZE == AMD_SD_2MB) ? 8'h00 : 8'h01);
    endproperty
    a_sdbase: assert property (p_sdbase) else $error("sdram base wrong");

    // once taken, the strap must not follow the pin any more
    property p_strap;
        @(posedge ref_clk) disable iff (rst)
        strap_taken_r |=> $stable(wiring_r);
    endproperty
    a_strap: assert property (p_strap) else $error("strap changed after capture");

    property p_miss;
        @(posedge ref_clk) disable iff (rst)
        unmapped_hit |-> route.valid && route.target == AMD_TGT_NONE;
    endproperty
    a_miss: assert property (p_miss) else $error("unmapped flag with a target");

    property p_kseg;
        @(posedge ref_clk) disable iff (rst)
        req.vaddr[31:29] == 3'h4 |=> route.segment == AMD_SEG_CACHED;
    endproperty
    a_kseg: assert property (p_kseg) else $error("cached segment not classified");

endmodule : amd_decoder

`default_nettype wire

//--- dv/amd_far_model.sv
// far-side model: peripheral bridge, external bus and sdram controller
// assumes route comes registered from the decoder on ref_clk
`timescale 1ns/1ps
`default_nettype none
module amd_far_model
    import amd_pkg::*;
(
    input  wire amd_route_type route,
    output logic               peripheral_bus_hit,
    output logic               ebus_hit,
    output logic               sdram_hit,
    output logic [31:0]        rd_data
);
    // ------------------------------------------------------------
    // target acceptance
    // ------------------------------------------------------------
    // the core region never reaches this side of the bridge
    assign peripheral_bus_hit  = route.valid && (route.target inside {AMD_TGT_CFG, AMD_TGT_ATTR,
                                                            AMD_TGT_IO});
    assign ebus_hit  = route.valid && (route.target inside {AMD_TGT_ROM, AMD_TGT_X8,
                                                            AMD_TGT_X16, AMD_TGT_X32});
    assign sdram_hit = route.valid && (route.target == AMD_TGT_SDRAM);
    // read data is the physical address when any far-side target accepts, else zero
    assign rd_data   = (peripheral_bus_hit || ebus_hit || sdram_hit) ? route.phys : 32'h00000000;
endmodule : amd_far_model
`default_nettype wire

//--- dv/tb_amd_decoder.sv
// self-checking bench for the cpu address decoder
// assumes the default sdram size of 16 mbyte and latency of one edge
`timescale 1ns/1ps
`default_nettype none
module tb_amd_decoder;
    import amd_pkg::*;
    logic          ref_clk;
    logic          rst;
    amd_req_type   req;
    logic          strap_pin;
    logic          ebus_demux_mode;
    amd_route_type route;
    logic          ebus_wiring_sel;
    logic          unmapped_hit;
    logic          peripheral_bus_hit;
    logic          ebus_hit;
    logic          sdram_hit;
    logic [31:0]   rd_data;
    int            err_count;
    int            checked;
    int            cycles = 0;

    amd_decoder dut_u (.ref_clk(ref_clk), .rst(rst), .req(req), .strap_pin(strap_pin),
        .ebus_demux_mode(ebus_demux_mode), .route(route), .ebus_wiring_sel(ebus_wiring_sel),
        .unmapped_hit(unmapped_hit));
    amd_far_model far_u (.route(route), .peripheral_bus_hit(peripheral_bus_hit),
        .ebus_hit(ebus_hit), .sdram_hit(sdram_hit), .rd_data(rd_data));

    // ------------------------------------------------------------
    // clock, timeout, helpers
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // whole run is well under 300 cycles
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            results();
        end
    end
    task automatic results();
        $display("errors %0d checks %0d", err_count, checked);
        if (err_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    // result visible one edge after the request is taken
    task automatic issue(input logic [31:0] va, input logic v, input logic w = 1'b0);
        @(posedge ref_clk);
        req <= '{valid: v, write: w, vaddr: va};
        @(posedge ref_clk);
        #1;
    endtask : issue
    task automatic hit(input logic [31:0] va, input amd_target_type t);
        issue(va, 1'b1);
        chk(32'(route.target), 32'(t), "target");
        chk(32'(route.valid), 32'h1, "valid");
    endtask : hit

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_segments();
        logic [31:0] va;
        for (int c = 0; c < 8; c++) begin
            va = {c[2:0], 29'h1fe01234};
            issue(va, 1'b1);
            chk(32'(route.segment), (c < 4) ? 32'h0 : ((c > 5) ? 32'h3 : 32'(c - 3)),
                "segment");
            chk(route.phys, (c == 4 || c == 5) ? {3'h0, va[28:0]} : va, "phys");
            if (c >= 6) begin
                chk(32'(route.target), 32'(AMD_TGT_NONE), "upper target");
                chk(32'(unmapped_hit), 32'h1, "upper unmapped");
            end
            if (c == 0 || c == 4 || c == 5) chk(32'(route.target), 32'(AMD_TGT_IO), "io");
        end
    endtask : t_segments
    task automatic pb(input logic [31:0] va, input amd_target_type t, input logic [23:0] a,
                      input logic [7:0] s);
        hit(va, t);
        chk(32'(route.peripheral_bus_addr), 32'(a), "peripheral_bus addr");
        chk(32'(route.slot), 32'(s), "slot");
        chk(32'(peripheral_bus_hit), 32'h1, "peripheral_bus hit");
    endtask : pb
    task automatic t_peripheral_bus();
        pb(32'hbff40c05, AMD_TGT_CFG, 24'hf40c05, 8'h03);
        pb(32'hbff7ffff, AMD_TGT_CFG, 24'hf7ffff, 8'hff);
        pb(32'hbff00804, AMD_TGT_ATTR, 24'hf00804, 8'h02);
        pb(32'hbfe34567, AMD_TGT_IO, 24'he34567, 8'h34);
        hit(32'hbfff0010, AMD_TGT_CORE);
        chk(32'(peripheral_bus_hit), 32'h0, "core off peripheral_bus");
    endtask : t_peripheral_bus
    task automatic eb(input logic [31:0] va, input amd_target_type t, input logic [31:0] a);
        hit(va, t);
        chk(route.ebus_addr, a, "ebus addr");
        chk(32'(ebus_hit), 32'h1, "ebus hit");
    endtask : eb
    task automatic t_ebus();
        @(posedge ref_clk);
        ebus_demux_mode <= 1'b0;
        eb(32'hb0123456, AMD_TGT_X32, 32'h10123456);
        chk(32'(route.ebus_wide), 32'h1, "wide");
        @(posedge ref_clk);
        ebus_demux_mode <= 1'b1;
        eb(32'hb8abcdef, AMD_TGT_X8, 32'h00abcdef);
        chk(32'(route.ebus_wide), 32'h0, "narrow");
        eb(32'h90123456, AMD_TGT_X32, 32'h00123456);
        chk(32'(route.ebus_wide), 32'h0, "x32 demux narrow");
        eb(32'h94fedcba, AMD_TGT_X16, 32'h00fedcba);
        eb(32'hbfdfffff, AMD_TGT_ROM, 32'h00dfffff);
        eb(32'h9fc00010, AMD_TGT_ROM, 32'h00c00010);
    endtask : t_ebus
    task automatic t_sdram();
        hit(32'h80000000, AMD_TGT_SDRAM);
        chk(route.sdram_addr, 32'h01000000, "sdram lo");
        chk(32'(sdram_hit), 32'h1, "sdram hit");
        chk(32'(ebus_hit), 32'h0, "sdram off ebus");
        hit(32'ha0ffffff, AMD_TGT_SDRAM);
        chk(route.sdram_addr, 32'h01ffffff, "sdram hi");
        hit(32'ha1000000, AMD_TGT_NONE);
    endtask : t_sdram
    task automatic t_unmapped();
        hit(32'hbff80000, AMD_TGT_NONE);
        chk(32'(unmapped_hit), 32'h1, "hole");
        chk(route.ebus_addr | route.sdram_addr | 32'(route.peripheral_bus_addr), 32'h0, "zero");
        chk(rd_data, 32'h0, "read zero");
        issue(32'hbff80000, 1'b0);
        chk(32'(unmapped_hit), 32'h0, "idle hole");
        chk(32'(route.valid), 32'h0, "idle valid");
        hit(32'hbfe00000, AMD_TGT_IO);
        chk(32'(unmapped_hit), 32'h0, "after hole");
        hit(32'h1ff80004, AMD_TGT_NONE);
        chk(32'(unmapped_hit), 32'h1, "user hole");
        issue(32'h80000010, 1'b1, 1'b1);
        chk(32'(route.write), 32'h1, "write");
        chk(32'(sdram_hit), 32'h1, "write sdram");
    endtask : t_unmapped
    task automatic t_strap(input logic s);
        @(posedge ref_clk);
        rst       <= 1'b1;
        req       <= '0;
        strap_pin <= s;
        repeat (10) @(posedge ref_clk);
        #1;
        chk(32'(route.target), 32'(AMD_TGT_NONE), "reset target");
        @(posedge ref_clk);
        rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        chk(32'(ebus_wiring_sel), 32'(s), "strap");
        strap_pin <= ~s;
        repeat (4) @(posedge ref_clk);
        #1;
        chk(32'(ebus_wiring_sel), 32'(s), "strap held");
    endtask : t_strap

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        err_count       = 0;
        checked         = 0;
        rst             = 1'b1;
        req             = '0;
        strap_pin       = 1'b1;
        ebus_demux_mode = 1'b1;
        t_strap(1'b1);
        t_segments();
        t_peripheral_bus();
        t_ebus();
        t_sdram();
        t_unmapped();
        t_strap(1'b0);
        results();
    end
endmodule : tb_amd_decoder
`default_nettype wire
